//--- fqpb_defs.vh
// Constants for the flash query protection and burst information table
`ifndef FQPB_DEFS_VH
`define FQPB_DEFS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define FQPB_ADDR_W        8
`define FQPB_DATA_W        16
`define FQPB_IDX_W         4
`define FQPB_CMD_W         8
`define FQPB_CFG_W         3

// ****************************************************************
// Command codes
// ****************************************************************
`define FQPB_CMD_QUERY     8'h98
`define FQPB_CMD_ARRAY     8'hff
`define FQPB_CMD_SETCFG    8'h60

// ****************************************************************
// Query addresses
// ****************************************************************
`define FQPB_ADDR_PTR_LO   8'h15
`define FQPB_ADDR_PTR_HI   8'h16
`define FQPB_ADDR_LAST     8'hff
`define FQPB_BASE_PTR      8'h39
`define FQPB_REL_FIRST     8'h0e
`define FQPB_REL_LAST      8'h19
`define FQPB_REL_TO_IDX    8'h0c

// ****************************************************************
// Table entries, reserved bits already zero
// ****************************************************************
`define FQPB_VAL_PTR_LO    16'h0039
`define FQPB_VAL_PTR_HI    16'h0000
`define FQPB_VAL_PROT_CNT  16'h0001
`define FQPB_VAL_PROT_DESC 16'h0080
`define FQPB_VAL_PROT_LOC  16'h0000
`define FQPB_VAL_PROT_FACT 16'h0003
`define FQPB_VAL_PROT_USER 16'h0004
`define FQPB_VAL_PAGE      16'h0003
`define FQPB_VAL_SYNC_CNT  16'h0004
`define FQPB_VAL_SYNC_1    16'h0001
`define FQPB_VAL_SYNC_2    16'h0002
`define FQPB_VAL_SYNC_3    16'h0003
`define FQPB_VAL_SYNC_4    16'h0007
`define FQPB_VAL_REGIONS   16'h0002
`define FQPB_VAL_ZERO      16'h0000

// ****************************************************************
// Table indices
// ****************************************************************
`define FQPB_IDX_PTR_LO    4'h0
`define FQPB_IDX_PTR_HI    4'h1

// ****************************************************************
// Burst capability codes and reset values
// ****************************************************************
`define FQPB_CAP_MASK      16'h0007
`define FQPB_CAP_4         3'h1
`define FQPB_CAP_8         3'h2
`define FQPB_CAP_16        3'h3
`define FQPB_CAP_CONT      3'h7
`define FQPB_LEN_4         8'h03
`define FQPB_LEN_8         8'h07
`define FQPB_LEN_16        8'h0f
`define FQPB_LEN_SINGLE    8'h00
`define FQPB_CFG_RESET     3'h0

`endif

//--- fqpb_host.sv
// Host controller model issuing commands and query reads
`include "fqpb_defs.vh"
module fqpb_host (
	input  wire                      core_clk,
	input  wire                      rd_ready,
	output logic                     cmd_valid,
	output logic [`FQPB_CMD_W-1:0]   cmd_code,
	output logic [`FQPB_DATA_W-1:0]  cmd_data,
	output logic                     rd_req,
	output logic                     rd_sync,
	output logic [`FQPB_ADDR_W-1:0]  rd_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_data = 16'h0000;
		rd_req = 1'b0;
		rd_sync = 1'b0;
		rd_addr = 8'h00;
	end
	// One-cycle command; released data lines show the inverse
	task cmd(input [7:0] c, input [15:0] d);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_data = d;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_data = ~d;
	endtask
	// Waits for ready, then holds the request over one taking edge
	task rd(input [7:0] a, input s);
		@(negedge core_clk);
		while (rd_ready !== 1'b1)
			@(negedge core_clk);
		rd_req = 1'b1;
		rd_sync = s;
		rd_addr = a;
		@(negedge core_clk);
		rd_req = 1'b0;
		rd_sync = 1'b0;
		rd_addr = ~a;
	endtask
endmodule // fqpb_host

//--- fqpb_props_properties.sv
// Assertion checker for the query table section, bound to its top module
`include "fqpb_defs.vh"
module fqpb_props (
	input wire                      core_clk,
	input wire                      rstn,
	input wire                      cmd_valid,
	input wire [`FQPB_CMD_W-1:0]    cmd_code,
	input wire [`FQPB_DATA_W-1:0]   cmd_data,
	input wire                      rd_req,
	input wire                      rd_sync,
	input wire [`FQPB_ADDR_W-1:0]   rd_addr,
	input wire                      rd_valid,
	input wire [`FQPB_DATA_W-1:0]   rd_data,
	input wire                      rd_last,
	input wire                      rd_ready,
	input wire                      query_mode,
	input wire                      burst_active,
	input wire [`FQPB_CFG_W-1:0]    burst_cfg
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Taken single query read
	wire tk = rd_req && rd_ready;
	wire tq = tk && query_mode && !rd_sync;
	array_zero_a: assert property (tk && !query_mode |=> rd_valid && rd_data == 16'h0000)
		else $error("array mode read not zero");
	ptr_word_a: assert property (tq && rd_addr == 8'h15 |=> rd_data == 16'h0039)
		else $error("base pointer word wrong");
	prot_count_a: assert property (tq && rd_addr == 8'h47 |=> rd_data == 16'h0001 && rd_last)
		else $error("field count wrong");
	prot_desc_a: assert property (tq && rd_addr == 8'h48 |=> rd_data == 16'h0080)
		else $error("field descriptor wrong");
	cap_zero_a: assert property (tq && rd_addr inside {[8'h4e:8'h51]} |=> rd_data[15:3] == 13'h0000)
		else $error("capability reserved bits set");
	cont_code_a: assert property (tq && rd_addr == 8'h51 |=> rd_data == 16'h0007)
		else $error("continuous code wrong");
	region_cnt_a: assert property (tq && rd_addr == 8'h52 |=> rd_data == 16'h0002)
		else $error("region count wrong");
	query_enter_a: assert property (cmd_valid && cmd_code == 8'h98 |=> query_mode)
		else $error("query mode not entered");
	burst_four_a: assert property (tk && query_mode && rd_sync && burst_cfg == 3'h1 |=> (!rd_last && burst_active && !rd_ready) [*3] ##1 rd_last)
		else $error("four word burst length wrong");
	valid_answer_a: assert property (tk |=> rd_valid)
		else $error("read answer missing");
	single_sync_a: assert property (tk && rd_sync && burst_cfg == 3'h0 |=> rd_last && rd_ready)
		else $error("code zero read not single");
endmodule // fqpb_props

bind fqpb_top fqpb_props u_props (.core_clk, .rstn, .cmd_valid, .cmd_code, .cmd_data,
	.rd_req, .rd_sync, .rd_addr, .rd_valid, .rd_data, .rd_last, .rd_ready,
	.query_mode, .burst_active, .burst_cfg);

//--- fqpb_rom.v
// Query table storage with registered read data
`include "fqpb_defs.vh"

module fqpb_rom (
	input  wire                      core_clk,
	input  wire                      rstn,
	input  wire                      rd_en,
	input  wire                      rd_hit,
	input  wire [`FQPB_IDX_W-1:0]    rd_idx,
	output reg  [`FQPB_DATA_W-1:0]   rd_q
);

	// ****************************************************************
	// Constant contents
	// ****************************************************************
	reg [`FQPB_DATA_W-1:0] word;

	always @* begin
		case (rd_idx)
			4'h0:    word = `FQPB_VAL_PTR_LO;
			4'h1:    word = `FQPB_VAL_PTR_HI;
			4'h2:    word = `FQPB_VAL_PROT_CNT;
			4'h3:    word = `FQPB_VAL_PROT_DESC;
			4'h4:    word = `FQPB_VAL_PROT_LOC;
			4'h5:    word = `FQPB_VAL_PROT_FACT;
			4'h6:    word = `FQPB_VAL_PROT_USER;
			4'h7:    word = `FQPB_VAL_PAGE;
			4'h8:    word = `FQPB_VAL_SYNC_CNT;
			4'h9:    word = `FQPB_VAL_SYNC_1 & `FQPB_CAP_MASK;
			4'ha:    word = `FQPB_VAL_SYNC_2 & `FQPB_CAP_MASK;
			4'hb:    word = `FQPB_VAL_SYNC_3 & `FQPB_CAP_MASK;
			4'hc:    word = `FQPB_VAL_SYNC_4 & `FQPB_CAP_MASK;
			4'hd:    word = `FQPB_VAL_REGIONS;
			default: word = `FQPB_VAL_ZERO;
		endcase
	end

	// ****************************************************************
	// Read register
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= `FQPB_VAL_ZERO;
		end else if (rd_en) begin
			// Misses and array mode read as zero
			rd_q <= rd_hit ? word : `FQPB_VAL_ZERO;
		end
	end

endmodule // fqpb_rom

//--- fqpb_top.v
// Query table section for protection, page and burst capability words
`include "fqpb_defs.vh"

module fqpb_top (
	input  wire                      core_clk,
	input  wire                      rstn,
	input  wire                      cmd_valid,
	input  wire [`FQPB_CMD_W-1:0]    cmd_code,
	input  wire [`FQPB_DATA_W-1:0]   cmd_data,
	input  wire                      rd_req,
	input  wire                      rd_sync,
	input  wire [`FQPB_ADDR_W-1:0]   rd_addr,
	output wire                      rd_valid,
	output wire [`FQPB_DATA_W-1:0]   rd_data,
	output wire                      rd_last,
	output wire                      rd_ready,
	output wire                      query_mode,
	output wire                      burst_active,
	output wire [`FQPB_CFG_W-1:0]    burst_cfg
);

	// ****************************************************************
	// State codes
	// ****************************************************************
	localparam [1:0] MD_ARRAY = 2'b01;
	localparam [1:0] MD_QUERY = 2'b10;
	localparam [1:0] BS_IDLE  = 2'b01;
	localparam [1:0] BS_RUN   = 2'b10;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [1:0]                mode_r;
	reg  [1:0]                mode_nxt;
	reg  [1:0]                bst_r;
	reg  [1:0]                bst_nxt;
	reg  [`FQPB_CFG_W-1:0]    cfg_r;
	reg  [`FQPB_CFG_W-1:0]    cfg_nxt;
	reg  [`FQPB_ADDR_W-1:0]   baddr_r;
	reg  [`FQPB_ADDR_W-1:0]   baddr_nxt;
	reg  [`FQPB_ADDR_W-1:0]   bcnt_r;
	reg  [`FQPB_ADDR_W-1:0]   bcnt_nxt;
	reg                       valid_r;
	reg                       last_r;
	reg                       last_nxt;
	reg                       qmode_r;
	reg                       qmode_nxt;
	reg                       bact_r;
	reg                       bact_nxt;
	reg                       valid_nxt;
	reg  [`FQPB_ADDR_W-1:0]   rem;
	reg                       hit;
	reg  [`FQPB_IDX_W-1:0]    idx;
	reg  [`FQPB_ADDR_W-1:0]   idx_wide;
	wire                      in_query;
	wire                      running;
	wire                      rd_take;
	wire                      issue;
	wire [`FQPB_ADDR_W-1:0]   cur_addr;
	wire [`FQPB_ADDR_W-1:0]   rel;

	// ****************************************************************
	// Burst length from capability code
	// ****************************************************************
	// Returns the number of words after the first one
	function [`FQPB_ADDR_W-1:0] fqpb_burst_rem;
		input [`FQPB_CFG_W-1:0]  code;
		input [`FQPB_ADDR_W-1:0] start;
		begin
			case (code)
				`FQPB_CAP_4:    fqpb_burst_rem = `FQPB_LEN_4;
				`FQPB_CAP_8:    fqpb_burst_rem = `FQPB_LEN_8;
				`FQPB_CAP_16:   fqpb_burst_rem = `FQPB_LEN_16;
				// Continuous runs up to the top of the address space
				`FQPB_CAP_CONT: fqpb_burst_rem = `FQPB_ADDR_LAST - start;
				default:        fqpb_burst_rem = `FQPB_LEN_SINGLE;
			endcase
		end
	endfunction

	// ****************************************************************
	// Mode control
	// ****************************************************************
	// Unknown codes leave the mode unchanged
	always @* begin
		mode_nxt = mode_r;
		if (cmd_valid) begin
			case (cmd_code)
				`FQPB_CMD_QUERY: mode_nxt = MD_QUERY;
				`FQPB_CMD_ARRAY: mode_nxt = MD_ARRAY;
				default:         mode_nxt = mode_r;
			endcase
		end
		// Fold any illegal code back to array mode
		case (mode_nxt)
			MD_ARRAY: mode_nxt = MD_ARRAY;
			MD_QUERY: mode_nxt = MD_QUERY;
			default:  mode_nxt = MD_ARRAY;
		endcase
	end

	// ****************************************************************
	// Burst configuration
	// ****************************************************************
	// Configuration keeps only the three code bits the host copies in
	always @* begin
		cfg_nxt = cfg_r;
		if (cmd_valid && (cmd_code == `FQPB_CMD_SETCFG)) begin
			cfg_nxt = cmd_data[`FQPB_CFG_W-1:0];
		end
	end

	// A read on the command edge still decodes with the old mode
	assign in_query = (mode_r == MD_QUERY);

	// ****************************************************************
	// Address selection and decode
	// ****************************************************************
	assign running  = (bst_r == BS_RUN);
	// Requests during a burst are dropped, the stream never stalls
	assign rd_take  = rd_req && !running;
	assign issue    = rd_take || running;
	assign cur_addr = running ? baddr_r : rd_addr;
	assign rel      = cur_addr - `FQPB_BASE_PTR;

	// ****************************************************************
	// Table decode
	// ****************************************************************
	// Pointer words sit at fixed addresses, the rest follow the pointer
	always @* begin
		hit      = 1'b0;
		idx      = `FQPB_IDX_PTR_LO;
		idx_wide = rel - `FQPB_REL_TO_IDX;
		if (cur_addr == `FQPB_ADDR_PTR_LO) begin
			hit = 1'b1;
			idx = `FQPB_IDX_PTR_LO;
		end else if (cur_addr == `FQPB_ADDR_PTR_HI) begin
			hit = 1'b1;
			idx = `FQPB_IDX_PTR_HI;
		end else if ((rel >= `FQPB_REL_FIRST) && (rel <= `FQPB_REL_LAST)) begin
			hit = 1'b1;
			idx = idx_wide[`FQPB_IDX_W-1:0];
		end
		// Outside query mode nothing of the table is visible
		hit = hit && in_query;
	end

	// ****************************************************************
	// Burst start
	// ****************************************************************
	// Array mode and plain reads never start a burst
	always @* begin
		rem = `FQPB_LEN_SINGLE;
		if (rd_take && rd_sync && in_query) begin
			rem = fqpb_burst_rem(cfg_r, rd_addr);
		end
	end

	// ****************************************************************
	// Burst sequencing
	// ****************************************************************
	// A fixed burst wraps at the top of the 8-bit query space
	always @* begin
		bst_nxt   = bst_r;
		baddr_nxt = baddr_r;
		bcnt_nxt  = bcnt_r;
		last_nxt  = 1'b0;
		case (bst_r)
			BS_IDLE: begin
				if (rd_take) begin
					baddr_nxt = rd_addr + 8'h01;
					bcnt_nxt  = rem;
					if (rem == `FQPB_LEN_SINGLE) begin
						last_nxt = 1'b1;
					end else begin
						bst_nxt = BS_RUN;
					end
				end
			end
			BS_RUN: begin
				baddr_nxt = baddr_r + 8'h01;
				// Count down the words still owed
				bcnt_nxt  = bcnt_r - 8'h01;
				if (bcnt_r == 8'h01) begin
					last_nxt = 1'b1;
					bst_nxt  = BS_IDLE;
				end
			end
			default: begin
				bst_nxt = BS_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Read return and status
	// ****************************************************************
	// Every issued word answers one cycle later, misses included
	always @* begin
		valid_nxt = issue;
		qmode_nxt = (mode_nxt == MD_QUERY);
		bact_nxt  = (bst_nxt == BS_RUN);
	end

	// ****************************************************************
	// Mode and configuration registers
	// ****************************************************************
	// The status copy follows the mode register edge for edge
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_r  <= MD_ARRAY;
			cfg_r   <= `FQPB_CFG_RESET;
			qmode_r <= 1'b0;
		end else begin
			mode_r  <= mode_nxt;
			cfg_r   <= cfg_nxt;
			qmode_r <= qmode_nxt;
		end
	end

	// ****************************************************************
	// Burst registers
	// ****************************************************************
	// The status copy follows the burst state edge for edge
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bst_r   <= BS_IDLE;
			baddr_r <= 8'h00;
			bcnt_r  <= 8'h00;
			bact_r  <= 1'b0;
		end else begin
			bst_r   <= bst_nxt;
			baddr_r <= baddr_nxt;
			bcnt_r  <= bcnt_nxt;
			bact_r  <= bact_nxt;
		end
	end

	// ****************************************************************
	// Read return registers
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			valid_r <= 1'b0;
			last_r  <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
			last_r  <= last_nxt;
		end
	end

	// ****************************************************************
	// Table storage
	// ****************************************************************
	// Read data leave the table through its own output register
	fqpb_rom u_rom (
		.core_clk (core_clk),
		.rstn     (rstn),
		.rd_en    (issue),
		.rd_hit   (hit),
		.rd_idx   (idx),
		.rd_q     (rd_data)
	);

	// ****************************************************************
	// Handshake output
	// ****************************************************************
	// Combinational so that the host sees the end of a burst at once
	assign rd_ready     = !running;

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	assign rd_valid     = valid_r;
	assign rd_last      = last_r;
	assign query_mode   = qmode_r;
	assign burst_active = bact_r;
	assign burst_cfg    = cfg_r;

endmodule // fqpb_top

//--- test_flash_query_protect_burst_info.sv
// Self-checking bench for the query table section
`include "fqpb_defs.vh"
module test_flash_query_protect_burst_info;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	wire         cmd_valid, rd_req, rd_sync, rd_valid, rd_last, rd_ready;
	wire         query_mode, burst_active;
	wire [7:0]   cmd_code, rd_addr;
	wire [15:0]  cmd_data, rd_data;
	wire [2:0]   burst_cfg;
	logic [15:0] wd [0:15];
	int          n_mismatch = 0;
	int          check_count = 0;
	always #10 core_clk = ~core_clk;
	fqpb_top dut (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rd_req(rd_req), .rd_sync(rd_sync),
		.rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
		.rd_ready(rd_ready), .query_mode(query_mode), .burst_active(burst_active),
		.burst_cfg(burst_cfg));
	fqpb_host host (.core_clk(core_clk), .rd_ready(rd_ready), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rd_req(rd_req), .rd_sync(rd_sync),
		.rd_addr(rd_addr));
	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rdchk(input [7:0] a, input [15:0] e);
		host.rd(a, 1'b0);
		chk("rd_valid", 16'h0001, {15'h0, rd_valid});
		chk("rd_last", 16'h0001, {15'h0, rd_last});
		chk("rd_data", e, rd_data);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_reset;
		chk("query_mode", 16'h0000, {15'h0, query_mode});
		chk("rd_ready", 16'h0001, {15'h0, rd_ready});
		chk("burst_cfg", 16'h0000, {13'h0, burst_cfg});
	endtask
	task t_array;
		rdchk(8'h47, 16'h0000);
	endtask
	task t_table;
		host.cmd(8'h98, 16'h0000);
		chk("query_mode", 16'h0001, {15'h0, query_mode});
		rdchk(8'h15, 16'h0039);
		rdchk(8'h16, 16'h0000);
		rdchk(8'h47, 16'h0001);
		rdchk(8'h48, 16'h0080);
		rdchk(8'h49, 16'h0000);
		rdchk(8'h4a, 16'h0003);
		rdchk(8'h4b, 16'h0004);
		rdchk(8'h4c, 16'h0003);
		rdchk(8'h4d, 16'h0004);
		rdchk(8'h4e, 16'h0001);
		rdchk(8'h4f, 16'h0002);
		rdchk(8'h50, 16'h0003);
		rdchk(8'h51, 16'h0007);
		rdchk(8'h52, 16'h0002);
		rdchk(8'h53, 16'h0000);
	endtask
	task t_burst(input [2:0] code, input [15:0] n, input [7:0] a);
		int cnt;
		host.cmd(8'h60, {13'h1fff, code});
		chk("burst_cfg", {13'h0, code}, {13'h0, burst_cfg});
		host.rd(a, 1'b1);
		chk("rd_ready", 16'h0000, {15'h0, rd_ready});
		chk("burst_active", 16'h0001, {15'h0, burst_active});
		chk("rd_valid", 16'h0001, {15'h0, rd_valid});
		wd[0] = rd_data;
		cnt = 1;
		while (rd_last !== 1'b1 && cnt < 300) begin
			@(negedge core_clk);
			chk("rd_valid", 16'h0001, {15'h0, rd_valid});
			if (cnt < 16)
				wd[cnt] = rd_data;
			cnt++;
		end
		chk("burst words", n, 16'(cnt));
		chk("rd_ready", 16'h0001, {15'h0, rd_ready});
		chk("burst_active", 16'h0000, {15'h0, burst_active});
	endtask
	task t_bursts;
		t_burst(3'h1, 16'd4, 8'h4e);
		chk("word0", 16'h0001, wd[0]);
		chk("word1", 16'h0002, wd[1]);
		chk("word2", 16'h0003, wd[2]);
		chk("word3", 16'h0007, wd[3]);
		t_burst(3'h2, 16'd8, 8'h4e);
		t_burst(3'h3, 16'd16, 8'h47);
		chk("word5", 16'h0003, wd[5]);
		t_burst(3'h7, 16'd16, 8'hf0);
		host.cmd(8'h01, 16'h0002);
		chk("burst_cfg", 16'h0007, {13'h0, burst_cfg});
		chk("query_mode", 16'h0001, {15'h0, query_mode});
		host.cmd(8'h60, 16'h0000);
		t_single(16'h0001);
		host.cmd(8'h60, 16'h0007);
	endtask
	task t_single(input [15:0] e);
		host.rd(8'h4e, 1'b1);
		chk("rd_valid", 16'h0001, {15'h0, rd_valid});
		chk("rd_last", 16'h0001, {15'h0, rd_last});
		chk("rd_ready", 16'h0001, {15'h0, rd_ready});
		chk("rd_data", e, rd_data);
	endtask
	task t_exit;
		host.cmd(8'hff, 16'h0000);
		chk("query_mode", 16'h0000, {15'h0, query_mode});
		rdchk(8'h4e, 16'h0000);
		t_single(16'h0000);
	endtask
	initial begin
		#100000;
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		t_reset;
		t_array;
		t_table;
		t_bursts;
		t_exit;
		summarize;
	end
endmodule // test_flash_query_protect_burst_info
